// *** trigger_sequencer_control_test.sv ***
// self-checking bench for the trigger sequencer control register bank
// assumes tsc_pkg, tsc_trig_if, tsc_trig_stage and tsc_ctrl are compiled beside it
`timescale 1ns/1ps
`include "tsc_defs.svh"
module trigger_sequencer_control_test;
    import tsc_pkg::*;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic       i_clock       = 1'b0;
    logic       i_srst        = 1'b1;
    tsc_addr_t  i_addr        = 8'h00;
    tsc_word_t  i_wdata       = 16'h0000;
    logic       i_wr          = 1'b0;
    logic       i_rd          = 1'b0;
    logic       i_idle        = 1'b0;
    logic       i_trig_cmd    = 1'b0;
    logic [1:0] i_trig_sel    = 2'h0;
    logic       i_swt_consume = 1'b0;
    logic       i_wdt_expire  = 1'b0;
    tsc_word_t  i_sd_live     = 16'h0a0a;
    tsc_word_t  i_cnt_live    = 16'h0b0b;
    tsc_word_t  i_tmr_live    = 16'h0c0c;
    tsc_word_t  o_rdata;
    logic       o_run;
    logic       o_single_step;
    logic       o_sw_trigger;
    logic [1:0] o_input_mode;
    tsc_lines_t o_trig_line;
    logic       o_irq;
    int         miscompares   = 0;
    int         num_checks    = 0;
    int         cycles        = 0;

    always #2.5 i_clock = ~i_clock;

    tsc_ctrl dut_u (
        .i_clock       (i_clock),
        .i_srst        (i_srst),
        .i_addr        (i_addr),
        .i_wdata       (i_wdata),
        .i_wr          (i_wr),
        .i_rd          (i_rd),
        .o_rdata       (o_rdata),
        .i_idle        (i_idle),
        .i_trig_cmd    (i_trig_cmd),
        .i_trig_sel    (i_trig_sel),
        .i_swt_consume (i_swt_consume),
        .i_wdt_expire  (i_wdt_expire),
        .i_sd_live     (i_sd_live),
        .i_cnt_live    (i_cnt_live),
        .i_tmr_live    (i_tmr_live),
        .o_run         (o_run),
        .o_single_step (o_single_step),
        .o_sw_trigger  (o_sw_trigger),
        .o_input_mode  (o_input_mode),
        .o_trig_line   (o_trig_line),
        .o_irq         (o_irq)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // the whole run needs under two hundred cycles; a hang stops at 5000, well past that
    always @(posedge i_clock)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            miscompares = miscompares + 1;
            conclude();
        end
    end

    task automatic check(input string name, input tsc_word_t exp, input tsc_word_t got);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // outputs packed as 0x0LMF: lines, input mode, then irq/swt/step/run
    task automatic outs(input tsc_word_t exp);
        check("outputs", exp, {4'h0, o_trig_line, 2'h0, o_input_mode, o_irq, o_sw_trigger, o_single_step, o_run});
    endtask : outs

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick

    task automatic bus_wr(input tsc_addr_t a, input tsc_word_t d);
        @(posedge i_clock);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr    <= 1'b0;
    endtask : bus_wr

    task automatic rd_chk(input string name, input tsc_addr_t a, input tsc_word_t exp);
        @(posedge i_clock);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        #1;
        check(name, exp, o_rdata);
    endtask : rd_chk

    task automatic fire(input logic [1:0] sel);
        @(posedge i_clock);
        i_trig_cmd <= 1'b1;
        i_trig_sel <= sel;
        @(posedge i_clock);
        i_trig_cmd <= 1'b0;
        #1;
    endtask : fire

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 7; i++)
            rd_chk("reset value", 8'(i * 4), 16'h0000);
        outs(16'h0000);
        tick(1);
        check("rdata after read", 16'h0000, o_rdata);
    endtask : t_reset

    task automatic t_fields();
        bus_wr(`TSC_OFF_CST, 16'hfbbf);
        rd_chk("cst unused bits", `TSC_OFF_CST, 16'hb383);
        tick(2);
        outs(16'h0033);
        @(posedge i_clock);
        i_idle <= 1'b1;
        tick(2);
        outs(16'h0032);
        bus_wr(`TSC_OFF_CST, 16'h9383);
        tick(2);
        outs(16'h0033);
        bus_wr(`TSC_OFF_CST, 16'h9301);
        tick(2);
        outs(16'h0012);
        bus_wr(`TSC_OFF_CST, 16'h1380);
        tick(2);
        outs(16'h0000);
        @(posedge i_clock);
        i_idle <= 1'b0;
    endtask : t_fields

    task automatic t_limits();
        bus_wr(`TSC_OFF_SDLIM, 16'h1111);
        bus_wr(`TSC_OFF_CLIM, 16'h2222);
        bus_wr(`TSC_OFF_TLIM, 16'h3333);
        bus_wr(`TSC_OFF_CST, 16'h8000);
        rd_chk("step delay limit", `TSC_OFF_SDLIM, 16'h1111);
        rd_chk("counter limit", `TSC_OFF_CLIM, 16'h2222);
        rd_chk("timer limit", `TSC_OFF_TLIM, 16'h3333);
        bus_wr(`TSC_OFF_CST, 16'h8100);
        rd_chk("live step delay", `TSC_OFF_SDLIM, 16'h0a0a);
        rd_chk("live counter", `TSC_OFF_CLIM, 16'h0b0b);
        rd_chk("live timer", `TSC_OFF_TLIM, 16'h0c0c);
        bus_wr(8'h1c, 16'hffff);
        rd_chk("unmapped 1c", 8'h1c, 16'h0000);
        rd_chk("unmapped 40", 8'h40, 16'h0000);
    endtask : t_limits

    task automatic t_swtrig();
        bus_wr(`TSC_OFF_CST, 16'h8400);
        tick(2);
        outs(16'h0004);
        bus_wr(`TSC_OFF_CST, 16'h8000);
        tick(2);
        outs(16'h0004);
        @(posedge i_clock);
        i_swt_consume <= 1'b1;
        @(posedge i_clock);
        i_swt_consume <= 1'b0;
        tick(2);
        outs(16'h0000);
        bus_wr(`TSC_OFF_CST, 16'h0400);
        tick(2);
        outs(16'h0000);
        rd_chk("trigger kept while off", `TSC_OFF_CST, 16'h0400);
        @(posedge i_clock);
        i_swt_consume <= 1'b1;
        @(posedge i_clock);
        i_swt_consume <= 1'b0;
    endtask : t_swtrig

    task automatic t_pulse();
        bus_wr(`TSC_OFF_PWD, 16'h0001);
        bus_wr(`TSC_OFF_IMASK, 16'h0003);
        bus_wr(`TSC_OFF_CST, 16'h8000);
        fire(2'h2);
        outs(16'h0408);
        tick(1);
        outs(16'h0408);
        tick(1);
        outs(16'h0008);
        fire(2'h0);
        outs(16'h0108);
        rd_chk("trigger status", `TSC_OFF_ISTAT, 16'h0002);
        bus_wr(`TSC_OFF_ISTAT, 16'h0002);
        tick(2);
        outs(16'h0000);
    endtask : t_pulse

    task automatic t_toggle();
        bus_wr(`TSC_OFF_IMASK, 16'h0000);
        bus_wr(`TSC_OFF_CST, 16'h9000);
        fire(2'h1);
        outs(16'h0200);
        tick(3);
        outs(16'h0200);
        fire(2'h1);
        outs(16'h0000);
        fire(2'h3);
        outs(16'h0800);
        fire(2'h0);
        outs(16'h0900);
        bus_wr(`TSC_OFF_ISTAT, 16'h0003);
        bus_wr(`TSC_OFF_CST, 16'h1000);
        tick(2);
        outs(16'h0000);
        fire(2'h0);
        tick(1);
        outs(16'h0000);
        rd_chk("status while off", `TSC_OFF_ISTAT, 16'h0000);
    endtask : t_toggle

    task automatic t_watchdog();
        bus_wr(`TSC_OFF_IMASK, 16'h0001);
        bus_wr(`TSC_OFF_CST, 16'h8000);
        rd_chk("no time-out", `TSC_OFF_CST, 16'h8000);
        @(posedge i_clock);
        i_wdt_expire <= 1'b1;
        @(posedge i_clock);
        i_wdt_expire <= 1'b0;
        #1;
        outs(16'h0008);
        rd_chk("time-out flag", `TSC_OFF_CST, 16'h8040);
        rd_chk("watchdog status", `TSC_OFF_ISTAT, 16'h0001);
        bus_wr(`TSC_OFF_IMASK, 16'h0000);
        tick(2);
        outs(16'h0000);
        bus_wr(`TSC_OFF_ISTAT, 16'h0001);
        bus_wr(`TSC_OFF_CST, 16'h8000);
        rd_chk("flag cleared", `TSC_OFF_CST, 16'h8000);
        rd_chk("status cleared", `TSC_OFF_ISTAT, 16'h0000);
        bus_wr(`TSC_OFF_CST, 16'h0000);
        @(posedge i_clock);
        i_wdt_expire <= 1'b1;
        @(posedge i_clock);
        i_wdt_expire <= 1'b0;
        rd_chk("time-out while off", `TSC_OFF_CST, 16'h0000);
    endtask : t_watchdog

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge i_clock);
        i_srst <= 1'b0;
        t_reset();
        t_fields();
        t_limits();
        t_swtrig();
        t_pulse();
        t_toggle();
        t_watchdog();
        // a second reset in mid-run must clear everything written before it
        bus_wr(`TSC_OFF_CST, 16'hfbbf);
        bus_wr(`TSC_OFF_PWD, 16'h000f);
        @(posedge i_clock);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_srst <= 1'b0;
        t_reset();
        conclude();
    end
endmodule : trigger_sequencer_control_test

// *** tsc_ctrl.sv ***
// trigger sequencer control/status register bank with limit and irq registers
// assumes a single-cycle strobe master on i_clock; engine signals are same-clock
`timescale 1ns/1ps
`include "tsc_defs.svh"
module tsc_ctrl (
    input  wire logic              i_clock,
    input  wire logic              i_srst,
    input  wire tsc_pkg::tsc_addr_t i_addr,
    input  wire tsc_pkg::tsc_word_t i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output tsc_pkg::tsc_word_t     o_rdata,
    input  wire logic              i_idle,
    input  wire logic              i_trig_cmd,
    input  wire logic [1:0]        i_trig_sel,
    input  wire logic              i_swt_consume,
    input  wire logic              i_wdt_expire,
    input  wire tsc_pkg::tsc_word_t i_sd_live,
    input  wire tsc_pkg::tsc_word_t i_cnt_live,
    input  wire tsc_pkg::tsc_word_t i_tmr_live,
    output logic                   o_run,
    output logic                   o_single_step,
    output logic                   o_sw_trigger,
    output logic [1:0]             o_input_mode,
    output tsc_pkg::tsc_lines_t    o_trig_line,
    output logic                   o_irq
);
    import tsc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic       module_enable;
    logic       stop_in_idle;
    logic       output_toggle;
    logic       software_trigger;
    logic       single_step;
    logic       visibility;
    logic       sequence_start;
    logic       wdt_flag;
    logic [1:0] input_mode;
    tsc_word_t  sd_lim;
    tsc_word_t  cnt_lim;
    tsc_word_t  tmr_lim;
    tsc_pwd_t   pulse_width;
    tsc_irq_t   irq_stat;
    tsc_irq_t   irq_mask;
    tsc_irq_t   next_irq_stat;
    tsc_word_t  next_rdata;
    logic       trig_event;

    tsc_trig_if tif ();

    function automatic logic hit(input tsc_addr_t a, input tsc_addr_t off);
        hit = (a == off);
    endfunction : hit

    function automatic tsc_word_t cst_word();
        cst_word = `TSC_RST_WORD;
        cst_word[`TSC_BIT_EN]   = module_enable;
        cst_word[`TSC_BIT_SIDL] = stop_in_idle;
        cst_word[`TSC_BIT_TOGL] = output_toggle;
        cst_word[`TSC_BIT_SWT]  = software_trigger;
        cst_word[`TSC_BIT_SSEN] = single_step;
        cst_word[`TSC_BIT_IVIS] = visibility;
        cst_word[`TSC_BIT_STRT] = sequence_start;
        cst_word[`TSC_BIT_WDTO] = wdt_flag;
        cst_word[`TSC_ITM_HI:`TSC_ITM_LO] = input_mode;
    endfunction : cst_word

    logic wr_cst;
    assign wr_cst = i_wr && hit(i_addr, `TSC_OFF_CST);

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    // only implemented fields are stored
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            module_enable  <= 1'b0;
            stop_in_idle   <= 1'b0;
            output_toggle  <= 1'b0;
            single_step    <= 1'b0;
            visibility     <= 1'b0;
            sequence_start <= 1'b0;
            input_mode     <= 2'h0;
        end
        else if (wr_cst)
        begin
            module_enable  <= i_wdata[`TSC_BIT_EN];
            stop_in_idle   <= i_wdata[`TSC_BIT_SIDL];
            output_toggle  <= i_wdata[`TSC_BIT_TOGL];
            single_step    <= i_wdata[`TSC_BIT_SSEN];
            visibility     <= i_wdata[`TSC_BIT_IVIS];
            sequence_start <= i_wdata[`TSC_BIT_STRT];
            input_mode     <= i_wdata[`TSC_ITM_HI:`TSC_ITM_LO];
        end
    end

    // ----------------------------------------------------------------
    // software trigger: set by write of one, cleared by its consumer
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            software_trigger <= 1'b0;
        // a write of one wins over a same-cycle consume
        else if (wr_cst && i_wdata[`TSC_BIT_SWT])
            software_trigger <= 1'b1;
        // only the control-step command consumes it
        else if (i_swt_consume)
            software_trigger <= 1'b0;
    end

    // ----------------------------------------------------------------
    // watchdog flag: hardware sets, a write of zero clears
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
            wdt_flag <= 1'b0;
        // expiry wins over a clearing write
        else if (i_wdt_expire && module_enable)
            wdt_flag <= 1'b1;
        else if (wr_cst && !i_wdata[`TSC_BIT_WDTO])
            wdt_flag <= 1'b0;
    end

    // ----------------------------------------------------------------
    // limit and pulse width registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            sd_lim      <= `TSC_RST_WORD;
            cnt_lim     <= `TSC_RST_WORD;
            tmr_lim     <= `TSC_RST_WORD;
            pulse_width <= `TSC_RST_PWD;
        end
        else if (i_wr)
        begin
            if (hit(i_addr, `TSC_OFF_SDLIM))
                sd_lim <= i_wdata;
            if (hit(i_addr, `TSC_OFF_CLIM))
                cnt_lim <= i_wdata;
            if (hit(i_addr, `TSC_OFF_TLIM))
                tmr_lim <= i_wdata;
            if (hit(i_addr, `TSC_OFF_PWD))
                pulse_width <= i_wdata[3:0];
        end
    end

    // ----------------------------------------------------------------
    // engine outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            o_run         <= 1'b0;
            o_single_step <= 1'b0;
            o_sw_trigger  <= 1'b0;
            o_input_mode  <= 2'h0;
        end
        else
        begin
            o_run         <= module_enable && sequence_start && !(stop_in_idle && i_idle);
            o_single_step <= module_enable && single_step;
            o_sw_trigger  <= module_enable && software_trigger;
            // only the wait commands look at this
            o_input_mode  <= input_mode;
        end
    end

    // ----------------------------------------------------------------
    // trigger stage
    // ----------------------------------------------------------------
    assign trig_event      = i_trig_cmd && module_enable;
    assign tif.fire        = trig_event;
    assign tif.sel         = i_trig_sel;
    assign tif.toggle_mode = output_toggle;
    assign tif.enable      = module_enable;
    assign tif.pulse_width = pulse_width;
    assign o_trig_line     = tif.line;

    tsc_trig_stage u_stage (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .p       (tif.stage)
    );

    // ----------------------------------------------------------------
    // interrupts: sticky, write one to clear, event wins
    // ----------------------------------------------------------------
    always_comb
    begin
        next_irq_stat = irq_stat;
        if (i_wr && hit(i_addr, `TSC_OFF_ISTAT))
            next_irq_stat = irq_stat & ~i_wdata[1:0];
        if (i_wdt_expire && module_enable)
            next_irq_stat[`TSC_IRQ_WDT] = 1'b1;
        if (trig_event)
            next_irq_stat[`TSC_IRQ_TRIG] = 1'b1;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst)
        begin
            irq_stat <= `TSC_RST_IRQ;
            irq_mask <= `TSC_RST_IRQ;
            o_irq    <= 1'b0;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            if (i_wr && hit(i_addr, `TSC_OFF_IMASK))
                irq_mask <= i_wdata[1:0];
            o_irq <= |(next_irq_stat & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // read path: data valid only in the cycle after the strobe
    // ----------------------------------------------------------------
    always_comb
    begin
        next_rdata = `TSC_RST_WORD;
        if (hit(i_addr, `TSC_OFF_CST))
            next_rdata = cst_word() & `TSC_CST_MASK;
        else if (hit(i_addr, `TSC_OFF_SDLIM))
            next_rdata = visibility ? i_sd_live : sd_lim;
        else if (hit(i_addr, `TSC_OFF_CLIM))
            next_rdata = visibility ? i_cnt_live : cnt_lim;
        else if (hit(i_addr, `TSC_OFF_TLIM))
            next_rdata = visibility ? i_tmr_live : tmr_lim;
        else if (hit(i_addr, `TSC_OFF_PWD))
            next_rdata = {12'h000, pulse_width};
        else if (hit(i_addr, `TSC_OFF_ISTAT))
            next_rdata = {14'h0, irq_stat};
        else if (hit(i_addr, `TSC_OFF_IMASK))
            next_rdata = {14'h0, irq_mask};
    end

    always_ff @(posedge i_clock)
    begin
        if (i_srst || !i_rd)
            o_rdata <= `TSC_RST_WORD;
        else
            o_rdata <= next_rdata;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_srst);

    sequence s_rd_sd;
        i_rd && hit(i_addr, `TSC_OFF_SDLIM);
    endsequence
    sequence s_swt_wr1;
        wr_cst && i_wdata[`TSC_BIT_SWT];
    endsequence

    run_gate_a: assert property (!module_enable |=> !o_run)
        else $error("sequencer runs while disabled");
    idle_halt_a: assert property ((stop_in_idle && i_idle) |=> !o_run)
        else $error("sequencer runs in idle with stop-in-idle set");
    idle_run_a: assert property ((module_enable && sequence_start && !stop_in_idle) |=> o_run)
        else $error("sequencer not running when started");
    swt_set_a: assert property (s_swt_wr1 |=> software_trigger ##1 (o_sw_trigger || !$past(module_enable)))
        else $error("software trigger write lost");
    swt_clear_a: assert property ($fell(software_trigger) |-> $past(i_swt_consume))
        else $error("software trigger cleared without consume");
    vis_live_a: assert property ((s_rd_sd and visibility) |=> o_rdata == $past(i_sd_live))
        else $error("live value not returned");
    vis_hold_a: assert property ((s_rd_sd and !visibility) |=> o_rdata == $past(sd_lim))
        else $error("written limit not returned");
    wdt_set_a: assert property ((i_wdt_expire && module_enable) |=> wdt_flag ##1 wdt_flag || $past(wr_cst))
        else $error("watchdog flag not set");
    rsvd_zero_a: assert property ((i_rd && hit(i_addr, `TSC_OFF_CST)) |=> (o_rdata & ~`TSC_CST_MASK) == 16'h0000)
        else $error("unused control bits read nonzero");
    rst_clear_a: assert property (@(posedge i_clock) disable iff (1'b0) i_srst |=> cst_word() == 16'h0000)
        else $error("fields not cleared by reset");
    irq_level_a: assert property (1'b1 |=> o_irq == |(irq_stat & $past(irq_mask)))
        else $error("interrupt output does not follow status and mask");
    rd_idle_a: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data shown without a read strobe");
    wdt_off_a: assert property ((!module_enable && !wdt_flag) |=> !wdt_flag)
        else $error("watchdog flag set while disabled");
    trig_off_a: assert property (!module_enable |=> o_trig_line == 4'h0)
        else $error("trigger line active while disabled");
    swt_zero_a: assert property ((wr_cst && !i_wdata[`TSC_BIT_SWT] && !i_swt_consume)
        |=> $stable(software_trigger))
        else $error("writing zero changed the software trigger");
endmodule : tsc_ctrl

// *** tsc_defs.svh ***
// constants of the trigger sequencer control block: offsets, fields, resets
// assumes the includer supplies the package types; definitions only
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TSC_OFF_CST      8'h00
`define TSC_OFF_SDLIM    8'h04
`define TSC_OFF_CLIM     8'h08
`define TSC_OFF_TLIM     8'h0c
`define TSC_OFF_PWD      8'h10
`define TSC_OFF_ISTAT    8'h14
`define TSC_OFF_IMASK    8'h18

// ----------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------
`define TSC_BIT_EN       15
`define TSC_BIT_SIDL     13
`define TSC_BIT_TOGL     12
`define TSC_BIT_SWT      10
`define TSC_BIT_SSEN     9
`define TSC_BIT_IVIS     8
`define TSC_BIT_STRT     7
`define TSC_BIT_WDTO     6
`define TSC_ITM_HI       1
`define TSC_ITM_LO       0
`define TSC_CST_MASK     16'hb7c3

// ----------------------------------------------------------------
// interrupt bits, reset values
// ----------------------------------------------------------------
`define TSC_IRQ_WDT      0
`define TSC_IRQ_TRIG     1
`define TSC_RST_WORD     16'h0000
`define TSC_RST_PWD      4'h0
`define TSC_RST_IRQ      2'h0

`endif

// *** tsc_pkg.sv ***
// types shared by the trigger sequencer control block
// assumes nothing beyond a SystemVerilog compiler
package tsc_pkg;
    typedef logic [15:0] tsc_word_t;
    typedef logic [7:0]  tsc_addr_t;
    typedef logic [3:0]  tsc_lines_t;
    typedef logic [3:0]  tsc_pwd_t;
    typedef logic [1:0]  tsc_irq_t;
    typedef enum logic [1:0] {TSC_RD_CST, TSC_RD_LIM, TSC_RD_OTHER} tsc_rdkind_t;
endpackage : tsc_pkg

// *** tsc_trig_if.sv ***
// link between the register bank and the trigger output stage
// assumes both ends share i_clock
`timescale 1ns/1ps
interface tsc_trig_if;
    import tsc_pkg::*;
    logic       fire;
    logic [1:0] sel;
    logic       toggle_mode;
    logic       enable;
    tsc_pwd_t   pulse_width;
    tsc_lines_t line;
    modport ctrl  (output fire, sel, toggle_mode, enable, pulse_width, input line);
    modport stage (input fire, sel, toggle_mode, enable, pulse_width, output line);
endinterface : tsc_trig_if

// *** tsc_trig_stage.sv ***
// trigger output stage: toggle or fixed-width pulse per line
// assumes fire is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`include "tsc_defs.svh"
module tsc_trig_stage (
    input  wire logic  i_clock,
    input  wire logic  i_srst,
    tsc_trig_if.stage  p
);
    import tsc_pkg::*;

    tsc_pwd_t cnt [4];

    // ----------------------------------------------------------------
    // per-line output
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (i_srst || !p.enable)
            begin
                p.line[i] <= 1'b0;
                cnt[i]    <= `TSC_RST_PWD;
            end
            else if (p.fire && p.sel == 2'(i))
            begin
                if (p.toggle_mode)
                    p.line[i] <= ~p.line[i];
                else
                begin
                    p.line[i] <= 1'b1;
                    cnt[i]    <= p.pulse_width;
                end
            end
            else if (cnt[i] != 4'h0)
                cnt[i] <= cnt[i] - 4'h1;
            else if (!p.toggle_mode)
                p.line[i] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_fire_tog0;
        p.fire && p.toggle_mode && p.enable && p.sel == 2'h0;
    endsequence
    sequence s_fire_pw1;
        p.fire && !p.toggle_mode && p.enable && p.pulse_width == 4'h1 && p.sel == 2'h0;
    endsequence

    toggle_flip_a: assert property (@(posedge i_clock) disable iff (i_srst)
        s_fire_tog0 |=> p.line[0] != $past(p.line[0]))
        else $error("toggle mode did not invert the line");
    pulse_width_a: assert property (@(posedge i_clock) disable iff (i_srst)
        s_fire_pw1 |=> p.line[0] [*2] ##1 (!p.line[0] || p.fire || !p.enable || $past(p.fire)))
        else $error("pulse width wrong");
endmodule : tsc_trig_stage
